// File: stc_pkg.sv
// package: register map, fields and constants of the sixteen-bit timer/counter
package stc_pkg;
  // offsets printed as register indices; byte address is index times four
  localparam logic [7:0] IDX_INTCTL = 8'h0B;
  localparam logic [7:0] IDX_FLAGS = 8'h0C;
  localparam logic [7:0] IDX_CNT_LO = 8'h0E;
  localparam logic [7:0] IDX_CNT_HI = 8'h0F;
  localparam logic [7:0] IDX_CTRL = 8'h10;
  localparam logic [7:0] IDX_ENABLES = 8'h8C;
  localparam logic [7:0] IDX_PORTB = 8'h06;
  localparam logic [7:0] IDX_PORTB_DIR = 8'h86;
  // control, flag and interrupt control field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_CS = 1;
  localparam int CTRL_NOSYNC = 2;
  localparam int CTRL_OSCEN = 3;
  localparam int CTRL_PS_LO = 4;
  localparam int FLAG_OVF = 0;
  localparam int INTCTL_GIE = 7;
  localparam int INTCTL_PEIE = 6;
  // reset values, control write mask and count maximum
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL_MASK = 8'h3F;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] ENABLES_RST = 8'h00;
  localparam logic [7:0] INTCTL_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  // internal clock: one count per instruction cycle of four clocks
  localparam int CLK_NS = 100;
  localparam int INSTR_NS = 400;
  localparam logic [1:0] INSTR_DIV_LAST = 2'(INSTR_NS / CLK_NS - 1);
  typedef enum logic [1:0] {
    STC_TIMER = 2'b00,
    STC_SYNC_CNT = 2'b01,
    STC_ASYNC_CNT = 2'b10
  } stc_mode_t;
  function automatic stc_mode_t stc_mode(input logic [7:0] ctrl);
    if (!ctrl[CTRL_CS]) begin
      return STC_TIMER;
    end else if (ctrl[CTRL_NOSYNC]) begin
      return STC_ASYNC_CNT;
    end
    return STC_SYNC_CNT;
  endfunction
endpackage

// File: stc_tick_if.sv
// interface: tick source to counter core
`timescale 1ns/1ns
interface stc_tick_if;
  logic tick;
  logic [1:0] ps_code;
  logic clr;
  modport src (output tick, input ps_code, input clr);
  modport dst (input tick, output ps_code, output clr);
endinterface

// File: stc_prescaler.sv
// prescaler: divides incoming edges by 1, 2, 4 or 8
`timescale 1ns/1ns
module stc_prescaler
  import stc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_edge,
  stc_tick_if.src tk
);
  logic [2:0] div;
  logic [2:0] next_div;
  logic hit;
  always_comb begin
    next_div = div + 3'h1;
    case (tk.ps_code)
      2'b11: hit = (div == 3'h7);
      2'b10: hit = (div[1:0] == 2'h3);
      2'b01: hit = div[0];
      default: hit = 1'b1;
    endcase
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div <= 3'h0;
    end else if (tk.clr) begin
      div <= 3'h0;
    end else if (i_edge) begin
      div <= next_div;
    end
  end
  assign tk.tick = i_edge & hit;
endmodule // stc_prescaler

// File: stc_timer.sv
// top: sixteen-bit timer/counter with APB register access
// Overview of operation
// - sixteen-bit count, two bytes, wraps to zero
// - wrap sets flag; interrupt only when enabled
// - source clear counts instruction cycles, sync ignored
// - source set counts external rising edges
// - prescale codes 11/10/01 divide by 8/4/2
// - sync bit clear synchronises external input
// - unsynchronised mode counts and wakes in sleep
// - unsynchronised mode offers no capture timebase
// - byte reads valid during unsynchronised counting
// - oscillator enable gates crystal inverter
// - enabled oscillator forces pin 6 input; pins 6 and 7 read zero
// - oscillator keeps running during sleep
// - special event trigger clears the count
// - source and sync bits pick mode
`timescale 1ns/1ns
module stc_timer
  import stc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_ext_clk,
  input wire logic i_sleep,
  input wire logic i_special_event,
  input wire logic [7:0] i_portb_pins,
  output logic o_irq,
  output logic o_wake,
  output logic o_osc_enable,
  output logic o_pin6_oe_block,
  output logic o_capture_timebase_valid,
  output logic [15:0] o_capture_timebase
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] ctrl;
  logic [7:0] flags;
  logic [7:0] enables;
  logic [7:0] intctl;
  logic [7:0] portb_dir;
  logic [15:0] count;
  logic ext_s1;
  logic ext_s2;
  logic ext_prev;
  logic [1:0] instr_div;
  logic raw_edge;
  logic wrap;
  stc_mode_t mode;
  stc_tick_if tk ();

  function automatic logic [7:0] idx_of(input logic [11:0] addr);
    return addr[9:2];
  endfunction

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic access;
  logic wr;
  logic [7:0] idx;
  logic mapped;
  assign access = i_psel & i_penable;
  assign wr = access & i_pwrite;
  assign idx = idx_of(i_paddr);
  always_comb begin
    case (idx)
      IDX_INTCTL, IDX_FLAGS, IDX_CNT_LO, IDX_CNT_HI, IDX_CTRL, IDX_ENABLES,
      IDX_PORTB, IDX_PORTB_DIR: mapped = (i_paddr[1:0] == 2'b00) & ~i_paddr[10] & ~i_paddr[11];
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------
  // clock source selection
  // ----------------------------------------
  assign mode = stc_mode(ctrl);
  // three flops; the second and the third feed the edge detector
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_s1 <= i_ext_clk;
      ext_s2 <= ext_s1;
      ext_prev <= ext_s2;
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      instr_div <= 2'h0;
    end else begin
      instr_div <= (instr_div == INSTR_DIV_LAST) ? 2'h0 : instr_div + 2'h1;
    end
  end
  // both counter modes see the synchronised edge; the unsynchronised mode differs in running through
  // sleep and in withholding the capture timebase, since this model has one clock and reads stay coherent
  always_comb begin
    if (!ctrl[CTRL_RUN]) begin
      raw_edge = 1'b0;
    end else begin
      case (mode)
        STC_TIMER: raw_edge = ~i_sleep & (instr_div == INSTR_DIV_LAST);
        STC_SYNC_CNT: raw_edge = ~i_sleep & ext_s2 & ~ext_prev;
        STC_ASYNC_CNT: raw_edge = ext_s2 & ~ext_prev;
        default: raw_edge = 1'b0;
      endcase
    end
  end
  assign tk.ps_code = ctrl[CTRL_PS_LO +: 2];
  assign tk.clr = wr & mapped & (idx == IDX_CNT_LO || idx == IDX_CNT_HI || idx == IDX_CTRL);
  stc_prescaler u_ps (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_edge(raw_edge),
    .tk(tk)
  );

  // ----------------------------------------
  // counter
  // ----------------------------------------
  assign wrap = tk.tick & (count == CNT_MAX);
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      count <= CNT_RST;
    end else if (i_special_event) begin
      count <= CNT_RST;
    end else if (wr & mapped & (idx == IDX_CNT_LO)) begin
      count[7:0] <= i_pwdata[7:0];
    end else if (wr & mapped & (idx == IDX_CNT_HI)) begin
      count[15:8] <= i_pwdata[7:0];
    end else if (tk.tick) begin
      count <= count + 16'h0001;
    end
  end
  // set wins over a software clear in the same cycle
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      flags <= FLAGS_RST;
    end else begin
      if (wr & mapped & (idx == IDX_FLAGS)) begin
        flags <= i_pwdata[7:0];
      end
      if (wrap) begin
        flags[FLAG_OVF] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl <= CTRL_RST;
      enables <= ENABLES_RST;
      intctl <= INTCTL_RST;
      portb_dir <= DIR_RST;
    end else if (wr & mapped) begin
      case (idx)
        IDX_CTRL: ctrl <= i_pwdata[7:0] & CTRL_MASK;
        IDX_ENABLES: enables <= i_pwdata[7:0];
        IDX_INTCTL: intctl <= i_pwdata[7:0];
        IDX_PORTB_DIR: portb_dir <= i_pwdata[7:0];
        default: ctrl <= ctrl;
      endcase
    end
  end

  // ----------------------------------------
  // apb answer: zero wait states
  // ----------------------------------------
  logic [7:0] rd_byte;
  always_comb begin
    case (idx)
      IDX_INTCTL: rd_byte = intctl;
      IDX_FLAGS: rd_byte = flags;
      IDX_CNT_LO: rd_byte = count[7:0];
      IDX_CNT_HI: rd_byte = count[15:8];
      IDX_CTRL: rd_byte = ctrl;
      IDX_ENABLES: rd_byte = enables;
      IDX_PORTB: rd_byte = ctrl[CTRL_OSCEN] ? {2'b00, i_portb_pins[5:0]} : i_portb_pins;
      IDX_PORTB_DIR: rd_byte = portb_dir;
      default: rd_byte = 8'h00;
    endcase
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_prdata <= 32'h00000000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~mapped;
      o_prdata <= (i_psel & ~i_penable & ~i_pwrite & mapped) ? {24'h000000, rd_byte} : 32'h0;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic irq_next;
  assign irq_next = flags[FLAG_OVF] & enables[FLAG_OVF];
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq <= 1'b0;
      o_wake <= 1'b0;
      o_osc_enable <= 1'b0;
      o_pin6_oe_block <= 1'b0;
      o_capture_timebase_valid <= 1'b0;
      o_capture_timebase <= 16'h0000;
    end else begin
      o_irq <= irq_next & intctl[INTCTL_GIE] & intctl[INTCTL_PEIE];
      o_wake <= irq_next & intctl[INTCTL_PEIE] & i_sleep;
      o_osc_enable <= ctrl[CTRL_OSCEN];
      o_pin6_oe_block <= ctrl[CTRL_OSCEN];
      o_capture_timebase_valid <= (mode != STC_ASYNC_CNT);
      o_capture_timebase <= (mode != STC_ASYNC_CNT) ? count : 16'h0000;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_wrap_sets_flag;
    @(posedge i_clk) disable iff (!i_rstn) wrap |=> flags[FLAG_OVF];
  endproperty
  a_wrap_sets_flag: assert property (p_wrap_sets_flag) else $error("flag not set on wrap");
  property p_tick_inc;
    @(posedge i_clk) disable iff (!i_rstn)
      tk.tick & ~i_special_event & ~tk.clr |=> count == $past(count) + 16'h0001;
  endproperty
  a_tick_inc: assert property (p_tick_inc) else $error("count did not advance");
  property p_stopped;
    @(posedge i_clk) disable iff (!i_rstn) ~ctrl[CTRL_RUN] & ~wr & ~i_special_event
      |=> count == $past(count);
  endproperty
  a_stopped: assert property (p_stopped) else $error("count moved while stopped");
  property p_special;
    @(posedge i_clk) disable iff (!i_rstn) i_special_event |=> count == 16'h0000;
  endproperty
  a_special: assert property (p_special) else $error("special event did not clear");
  property p_div8;
    @(posedge i_clk) disable iff (!i_rstn)
      tk.tick & (tk.ps_code == 2'b11) & ~tk.clr |=> ~tk.tick [*1];
  endproperty
  a_div8: assert property (p_div8) else $error("prescale tick too soon");
  property p_timer_rate;
    @(posedge i_clk) disable iff (!i_rstn)
      (mode == STC_TIMER) & raw_edge |=> ~raw_edge ##1 ~raw_edge ##1 ~raw_edge;
  endproperty
  a_timer_rate: assert property (p_timer_rate) else $error("timer rate wrong");
  property p_irq_gate;
    @(posedge i_clk) disable iff (!i_rstn) o_irq |-> $past(enables[FLAG_OVF]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
  property p_sticky;
    @(posedge i_clk) disable iff (!i_rstn)
      flags[FLAG_OVF] & ~(wr & mapped & (idx == IDX_FLAGS)) |=> flags[FLAG_OVF];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");
  property p_async_base;
    @(posedge i_clk) disable iff (!i_rstn)
      mode == STC_ASYNC_CNT |=> ~o_capture_timebase_valid;
  endproperty
  a_async_base: assert property (p_async_base) else $error("timebase offered async");
  property p_sleep_count;
    @(posedge i_clk) disable iff (!i_rstn)
      i_sleep & (mode != STC_ASYNC_CNT) |-> ~raw_edge;
  endproperty
  a_sleep_count: assert property (p_sleep_count) else $error("counted in sleep");
  property p_osc_pins;
    @(posedge i_clk) disable iff (!i_rstn)
      ctrl[CTRL_OSCEN] |=> o_pin6_oe_block & o_osc_enable;
  endproperty
  a_osc_pins: assert property (p_osc_pins) else $error("pins not forced input");
  property p_irq_raise;
    @(posedge i_clk) disable iff (!i_rstn)
      irq_next & intctl[INTCTL_GIE] & intctl[INTCTL_PEIE] |=> o_irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("irq not raised");
  property p_div1;
    @(posedge i_clk) disable iff (!i_rstn)
      raw_edge & (tk.ps_code == 2'b00) |-> tk.tick;
  endproperty
  a_div1: assert property (p_div1) else $error("undivided edge lost");
  c_div8_tick: cover property (@(posedge i_clk) disable iff (!i_rstn)
    tk.tick & (tk.ps_code == 2'b11));
  c_wrap: cover property (@(posedge i_clk) disable iff (!i_rstn) wrap);
  c_async_sleep: cover property (@(posedge i_clk) disable iff (!i_rstn)
    i_sleep & tk.tick);
  c_irq: cover property (@(posedge i_clk) disable iff (!i_rstn) o_irq);
endmodule // stc_timer

// File: stc_ext_src.sv
// partner model: external count clock that runs only while enabled
`timescale 1ns/1ns
module stc_ext_src #(
  parameter int HALF_NS = 370
) (
  input wire logic i_en,
  output logic o_ext,
  output int o_edges
);
  // ----------------------------------------
  // edge generator
  // ----------------------------------------
  // line rests low between bursts, as a stopped source would
  initial begin
    o_ext = 1'b0;
    o_edges = 0;
    forever begin
      wait (i_en);
      #(HALF_NS) o_ext = 1'b1;
      o_edges++;
      #(HALF_NS) o_ext = 1'b0;
    end
  end
endmodule // stc_ext_src

// File: tb_stc_timer.sv
// testbench: register access, counting modes and flags of the timer/counter
`timescale 1ns/1ns
`define CHK(got, exp, msg) begin n_compared++; if ((got) !== (exp)) begin failures++; \
  $display("wrong value at %0t: %s", $time, msg); end end
module tb_stc_timer;
  import stc_pkg::*;
  logic i_clk, i_rstn, psel, penable, pwrite, sleep, sev, ext_en, ext_clk;
  logic pready, pslverr, irq, wake, osc, pin_blk, tb_valid, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [15:0] tbase;
  logic [7:0] pins, rd;
  int failures, n_compared, cycles, n_edges, e0;
  // reference model of count, prescaler phase and control
  int m_cnt, m_div, m_ctrl;

  stc_timer DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_ext_clk(ext_clk), .i_sleep(sleep),
    .i_special_event(sev), .i_portb_pins(pins), .o_irq(irq), .o_wake(wake),
    .o_osc_enable(osc), .o_pin6_oe_block(pin_blk), .o_capture_timebase_valid(tb_valid),
    .o_capture_timebase(tbase));
  stc_ext_src src (.i_en(ext_en), .o_ext(ext_clk), .o_edges(n_edges));

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic wrap_up();
    if (failures == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // a hung handshake is caught here rather than in the bus task
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // bus and stimulus tasks
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
    if (idx == IDX_CTRL) begin
      m_ctrl = int'(d & CTRL_MASK);
      m_div = 0;
    end else if (idx == IDX_CNT_LO) begin
      m_cnt = (m_cnt & 32'h0000FF00) | int'(d);
      m_div = 0;
    end else if (idx == IDX_CNT_HI) begin
      m_cnt = (m_cnt & 32'h000000FF) | (int'(d) << 8);
      m_div = 0;
    end
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input string msg);
    apb(1'b0, idx, 8'h00);
    `CHK(rd, exp, msg)
  endtask

  task automatic pulses(input int n);
    e0 = n_edges;
    ext_en <= 1'b1;
    if (m_ctrl[CTRL_RUN] && m_ctrl[CTRL_CS] && (m_ctrl[CTRL_NOSYNC] || !sleep)) begin
      for (int k = 0; k < n; k++) begin
        m_div = (m_div + 1) % (1 << ((m_ctrl >> CTRL_PS_LO) & 3));
        if (m_div == 0) begin
          m_cnt = (m_cnt + 1) & 32'h0000FFFF;
        end
      end
    end
    while (n_edges < e0 + n) @(posedge i_clk);
    ext_en <= 1'b0;
    repeat (10) @(posedge i_clk);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    i_rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    sleep = 1'b0;
    sev = 1'b0;
    ext_en = 1'b0;
    pins = 8'h00;
    seed = 32'h8A2A;
    m_cnt = int'(CNT_RST);
    m_div = 0;
    m_ctrl = int'(CTRL_RST);
    repeat (6) @(posedge i_clk);
    i_rstn <= 1'b1;
    rdchk(IDX_CTRL, CTRL_RST, "control reset");
    rdchk(IDX_FLAGS, FLAGS_RST, "flag reset");
    rdchk(IDX_ENABLES, ENABLES_RST, "enable reset");
    rdchk(IDX_CNT_LO, CNT_RST[7:0], "count reset");
    apb(1'b0, 8'h11, 8'h00);
    `CHK(err, 1'b1, "unmapped index")
    wr(IDX_CTRL, 8'hF4);
    rdchk(IDX_CTRL, 8'hF4 & CTRL_MASK, "control bits");
    seed = lfsr(seed);
    wr(IDX_CNT_HI, seed[15:8]);
    wr(IDX_CNT_LO, seed[7:0]);
    rdchk(IDX_CNT_HI, seed[15:8], "high byte rw");
    rdchk(IDX_CNT_LO, seed[7:0], "low byte rw");
    sev <= 1'b1;
    @(posedge i_clk);
    sev <= 1'b0;
    m_cnt = 0;
    rdchk(IDX_CNT_LO, 8'h00, "event clear low");
    rdchk(IDX_CNT_HI, 8'h00, "event clear high");
    // timer mode, sync bit set but ignored, divide by four
    wr(IDX_CTRL, 8'h25);
    repeat (318) @(posedge i_clk);
    wr(IDX_CTRL, 8'h24);
    apb(1'b0, IDX_CNT_LO, 8'h00);
    `CHK(rd >= 8'h13 && rd <= 8'h15, 1'b1, "timer rate")
    e0 = int'(rd);
    repeat (40) @(posedge i_clk);
    rdchk(IDX_CNT_LO, 8'(e0), "stopped count");
    for (int ps = 0; ps < 4; ps++) begin
      wr(IDX_CTRL, 8'h00);
      wr(IDX_CNT_LO, 8'h00);
      wr(IDX_CNT_HI, 8'h00);
      wr(IDX_CTRL, 8'(ps << 4) | 8'h03);
      pulses(16);
      `CHK(tb_valid, 1'b1, "sync timebase")
      `CHK(tbase, 16'(m_cnt), "timebase follows count")
      rdchk(IDX_CNT_LO, 8'(16 >> ps), "prescaled edges");
      rdchk(IDX_CNT_HI, 8'(m_cnt >> 8), "model high byte");
    end
    wr(IDX_CTRL, 8'h00);
    wr(IDX_CNT_HI, 8'hFF);
    wr(IDX_CNT_LO, 8'hFA);
    wr(IDX_ENABLES, 8'h01);
    wr(IDX_INTCTL, 8'h40);
    wr(IDX_CTRL, 8'h07);
    sleep <= 1'b1;
    pulses(5);
    `CHK(tb_valid, 1'b0, "async timebase")
    `CHK(tbase, 16'h0000, "async timebase value")
    rdchk(IDX_CNT_LO, 8'hFF, "async count in sleep");
    rdchk(IDX_FLAGS, 8'h00, "no early flag");
    pulses(1);
    `CHK(wake, 1'b1, "wake on overflow")
    sleep <= 1'b0;
    rdchk(IDX_CNT_HI, 8'h00, "wrap high byte");
    rdchk(IDX_CNT_LO, 8'(m_cnt), "model wrap low");
    rdchk(IDX_FLAGS, 8'h01, "overflow flag");
    `CHK(irq, 1'b0, "irq without global enable")
    wr(IDX_INTCTL, 8'hC0);
    repeat (2) @(posedge i_clk);
    `CHK(irq, 1'b1, "irq raised")
    wr(IDX_ENABLES, 8'h00);
    repeat (2) @(posedge i_clk);
    `CHK(irq, 1'b0, "irq masked")
    rdchk(IDX_FLAGS, 8'h01, "flag sticky");
    wr(IDX_FLAGS, 8'h00);
    rdchk(IDX_FLAGS, 8'h00, "flag cleared");
    wr(IDX_CTRL, 8'h00);
    seed = lfsr(seed);
    pins <= seed[7:0];
    sleep <= 1'b1;
    wr(IDX_CTRL, 8'h08);
    repeat (20) @(posedge i_clk);
    `CHK(osc, 1'b1, "oscillator on in sleep")
    `CHK(pin_blk, 1'b1, "pins forced input")
    rdchk(IDX_PORTB, seed[7:0] & 8'h3F, "port reads masked");
    sleep <= 1'b0;
    wr(IDX_CTRL, 8'h00);
    repeat (2) @(posedge i_clk);
    `CHK(osc, 1'b0, "oscillator off")
    rdchk(IDX_PORTB, seed[7:0], "port reads pins");
    wrap_up();
  end
endmodule // tb_stc_timer
